// [nbcd_output_port.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Six digit registers, each an 8-stage shift section plus holding section.
// - Serial data shifts in on rising edges of the active reading's clock.
// - While a load strobe is high, shift stages copy into holding stages.
// - Holding contents drive outputs continuously, never tri-stated.
// - Readings A and B update alternately by their own clock and strobe.
// - Update-inhibit is high whenever either load strobe is high; here it rises one clock after the synchronised, filtered strobe.
// - Output data stays stable and valid after each inhibit pulse.
// - Each holding bit is driven out unchanged, non-inverted.
// - 24 lines per reading, four BCD lines per digit, weights 8-4-2-1.
// - Register index maps to digit; index 1 least, 6 most significant.
// - Update-inhibit is a positive pulse of at least two microseconds.
module nbcd_output_port #(
   parameter int unsigned DIGITS = nbcd_pkg::NBCD_DIGITS,
   parameter int unsigned STAGES = nbcd_pkg::NBCD_STAGES
) (
   // Clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_reset,
   // Receiver control pins
   input  wire nbcd_pkg::nbcd_pins_t  i_pins,
   // Parallel BCD outputs
   output logic [4*DIGITS-1:0]        o_time_difference_a_value,
   output logic [4*DIGITS-1:0]        o_time_difference_b_value,
   output logic                       o_update_inhibit
);
   import nbcd_pkg::*;

   generate
      if (STAGES != 2 * NBCD_BCD_W || DIGITS != NBCD_DIGITS) begin : g_bad_geometry
         $error("nbcd_output_port: unsupported digit or stage count");
      end
   endgenerate

   // A change counts once stages two and three agree
   function automatic logic agreed(input logic s2, input logic s3, input logic prev);
      agreed = (s2 == s3) ? s3 : prev;
   endfunction : agreed

   // Three-stage synchroniser on every pin
   nbcd_pins_t sync1_r, sync2_r, sync3_r;
   nbcd_pins_t sync1_nxt, sync2_nxt, sync3_nxt;
   nbcd_pins_t lvl_r, lvl_nxt;
   logic       rise_a, rise_b, load_a, load_b;

   always_comb begin
      sync1_nxt = i_pins;
      sync2_nxt = sync1_r;
      sync3_nxt = sync2_r;
      lvl_nxt   = lvl_r;
      for (int i = 0; i < $bits(nbcd_pins_t); i++) begin
         lvl_nxt[i] = agreed(sync2_r[i], sync3_r[i], lvl_r[i]);
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         sync1_r <= NBCD_PINS_RST;
         sync2_r <= NBCD_PINS_RST;
         sync3_r <= NBCD_PINS_RST;
         lvl_r   <= NBCD_PINS_RST;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         sync3_r <= sync3_nxt;
         lvl_r   <= lvl_nxt;
      end
   end

   // Edge on the filtered level, so glitches shorter than two cycles vanish
   assign rise_a = lvl_nxt.serial_clock_first_reading  & ~lvl_r.serial_clock_first_reading;
   assign rise_b = lvl_nxt.serial_clock_second_reading & ~lvl_r.serial_clock_second_reading;
   assign load_a = lvl_r.load_strobe_first;
   assign load_b = lvl_r.load_strobe_second;

   // Digit registers
   logic [STAGES-1:0] shift_r [DIGITS];
   logic [STAGES-1:0] shift_nxt [DIGITS];
   logic [STAGES-1:0] hold_r [DIGITS];
   logic [STAGES-1:0] hold_nxt [DIGITS];
   logic [4*DIGITS-1:0] shift_a_flat, shift_b_flat;

   genvar d;
   generate
      for (d = 0; d < DIGITS; d++) begin : g_digit
         always_comb begin
            shift_nxt[d] = shift_r[d];
            hold_nxt[d]  = hold_r[d];
            if (rise_a || rise_b) begin
               shift_nxt[d] = {shift_r[d][STAGES-2:0], lvl_r.serial_data[d]};
            end
            // Low stages carry reading A, high stages reading B
            if (load_a) begin
               hold_nxt[d][NBCD_BCD_W-1:0] = shift_r[d][NBCD_BCD_W-1:0];
            end
            if (load_b) begin
               hold_nxt[d][STAGES-1:NBCD_BCD_W] = shift_r[d][STAGES-1:NBCD_BCD_W];
            end
         end

         always_ff @(posedge i_clock or posedge i_reset) begin
            if (i_reset) begin
               shift_r[d] <= NBCD_REG_RST;
               hold_r[d]  <= NBCD_REG_RST;
            end else begin
               shift_r[d] <= shift_nxt[d];
               hold_r[d]  <= hold_nxt[d];
            end
         end

         // Digit 0 here is digit index 1, least significant; bit 3 weighs 8
         assign o_time_difference_a_value[4*d +: 4] = hold_r[d][NBCD_BCD_W-1:0];
         assign o_time_difference_b_value[4*d +: 4] = hold_r[d][STAGES-1:NBCD_BCD_W];
         assign shift_a_flat[4*d +: 4] = shift_r[d][NBCD_BCD_W-1:0];
         assign shift_b_flat[4*d +: 4] = shift_r[d][STAGES-1:NBCD_BCD_W];
      end
   endgenerate

   // Update-inhibit: strobe level stretched to the minimum pulse width
   logic [NBCD_CNT_W-1:0] inh_cnt_r, inh_cnt_nxt;
   logic                  inh_r, inh_nxt;

   always_comb begin
      inh_cnt_nxt = inh_cnt_r;
      if (load_a || load_b) begin
         inh_cnt_nxt = NBCD_CNT_W'(NBCD_INHIBIT_CYC - 1);
      end else if (inh_cnt_r != NBCD_CNT_RST) begin
         inh_cnt_nxt = inh_cnt_r - 6'h01;
      end
      // Rises on the same edge as the load, so no sample sees half a change
      inh_nxt = load_a | load_b | (inh_cnt_r != NBCD_CNT_RST);
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         inh_cnt_r <= NBCD_CNT_RST;
         inh_r     <= 1'b0;
      end else begin
         inh_cnt_r <= inh_cnt_nxt;
         inh_r     <= inh_nxt;
      end
   end

   assign o_update_inhibit = inh_r;

   // Checks
   localparam int INH_MIN = NBCD_INHIBIT_CYC;
   logic [NBCD_CNT_W:0] inh_len_r, inh_len_nxt;

   // Length of the current inhibit pulse; saturates so a held strobe cannot wrap it
   always_comb begin
      inh_len_nxt = 7'h00;
      if (inh_r && inh_len_r != 7'h7f) begin
         inh_len_nxt = inh_len_r + 7'h01;
      end else if (inh_r) begin
         inh_len_nxt = inh_len_r;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         inh_len_r <= 7'h00;
      end else begin
         inh_len_r <= inh_len_nxt;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   sequence s_load;
      load_a || load_b;
   endsequence
   sequence s_only_a;
      load_a && !load_b;
   endsequence
   sequence s_only_b;
      load_b && !load_a;
   endsequence
   sequence s_shift_any;
      rise_a || rise_b;
   endsequence
   sequence s_counting;
      inh_cnt_r != NBCD_CNT_RST;
   endsequence

   a_inhibit_on_load: assert property (s_load |=> o_update_inhibit)
      else $error("inhibit not high during load");
   // At the falling edge the count holds the full pulse length
   a_inhibit_min_width: assert property ($fell(o_update_inhibit) |->
      inh_len_r >= INH_MIN - 1)
      else $error("inhibit pulse shorter than minimum");
   a_inhibit_ends: assert property (!load_a && !load_b && inh_cnt_r == 6'h00 |=> !o_update_inhibit)
      else $error("inhibit held without cause");
   a_data_stable_a: assert property (!o_update_inhibit |-> $stable(o_time_difference_a_value))
      else $error("reading A changed outside inhibit");
   a_data_stable_b: assert property (!o_update_inhibit |-> $stable(o_time_difference_b_value))
      else $error("reading B changed outside inhibit");
   a_load_a_only: assert property (s_only_a |=> $stable(o_time_difference_b_value))
      else $error("reading B changed on A load");
   a_load_b_only: assert property (s_only_b |=> $stable(o_time_difference_a_value))
      else $error("reading A changed on B load");
   a_load_copy_a: assert property (load_a |=> o_time_difference_a_value == $past(shift_a_flat))
      else $error("A holding stages not copied");
   a_load_copy_b: assert property (load_b |=> o_time_difference_b_value == $past(shift_b_flat))
      else $error("B holding stages not copied");
   a_shift_step: assert property (rise_a |=> shift_r[0] == {$past(shift_r[0][STAGES-2:0]), $past(lvl_r.serial_data[0])})
      else $error("shift section did not step");
   a_shift_idle: assert property (!rise_a && !rise_b |=> shift_r[0] == $past(shift_r[0]))
      else $error("shift section moved without clock");
   a_inhibit_counting: assert property (s_counting |=> o_update_inhibit)
      else $error("inhibit dropped while stretching");
   a_shift_step_top: assert property (s_shift_any |=> shift_r[DIGITS-1] ==
      {$past(shift_r[DIGITS-1][STAGES-2:0]), $past(lvl_r.serial_data[DIGITS-1])})
      else $error("top digit shift section did not step");
   a_hold_a_quiet: assert property (!load_a |=> $stable(o_time_difference_a_value))
      else $error("reading A changed without its strobe");
   a_hold_b_quiet: assert property (!load_b |=> $stable(o_time_difference_b_value))
      else $error("reading B changed without its strobe");
endmodule : nbcd_output_port

// [nbcd_output_port_test.sv]
`timescale 1ns/1ps
module nbcd_output_port_test;
   import nbcd_pkg::*;
   localparam logic [23:0] VA = 24'h12_3457;
   localparam logic [23:0] VB = 24'h90_8165;
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   nbcd_pins_t  pins    = NBCD_PINS_RST;
   logic [23:0] val_a, val_b, cap_a, cap_b;
   logic        inh;
   int          caps, err_count = 0, checks_done = 0;
   always #25 i_clock = ~i_clock;
   nbcd_output_port DUT (.i_clock(i_clock), .i_reset(i_reset), .i_pins(pins),
      .o_time_difference_a_value(val_a), .o_time_difference_b_value(val_b),
      .o_update_inhibit(inh));
   nbcd_telemetry_model partner (.i_update_inhibit(inh), .i_value_a(val_a),
      .i_value_b(val_b), .o_cap_a(cap_a), .o_cap_b(cap_b), .o_caps(caps));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Each bit held well around the clock rise, since pins pass a filter
   task automatic shift_nib(input logic [23:0] v, input bit b);
      for (int i = 3; i >= 0; i--) begin
         for (int d = 0; d < 6; d++) pins.serial_data[d] <= v[4*d+i];
         repeat (4) @(posedge i_clock);
         if (b) pins.serial_clock_second_reading <= 1'b1;
         else pins.serial_clock_first_reading <= 1'b1;
         repeat (4) @(posedge i_clock);
         pins.serial_clock_second_reading <= 1'b0;
         pins.serial_clock_first_reading  <= 1'b0;
         repeat (4) @(posedge i_clock);
      end
   endtask : shift_nib
   task automatic strobe(input bit b);
      int n;
      n = 0;
      if (b) pins.load_strobe_second <= 1'b1;
      else pins.load_strobe_first <= 1'b1;
      repeat (3) @(posedge i_clock);
      pins.load_strobe_second <= 1'b0;
      pins.load_strobe_first  <= 1'b0;
      while (inh !== 1'b1 && n < 20) begin
         @(negedge i_clock);
         n++;
      end
      chk({23'h0, inh}, 24'h00_0001);
      n = 0;
      while (inh === 1'b1 && n < 100) begin
         @(negedge i_clock);
         n++;
      end
      chk({23'h0, n >= NBCD_INHIBIT_CYC && n < 100}, 24'h00_0001);
      repeat (4) @(posedge i_clock);
   endtask : strobe
   task automatic test_reset;
      chk(val_a, 24'h00_0000);
      chk(val_b, 24'h00_0000);
      chk({23'h0, inh}, 24'h00_0000);
   endtask : test_reset
   task automatic test_load_a;
      shift_nib(VA, 1'b0);
      chk(val_a, 24'h00_0000);
      strobe(1'b0);
      chk(val_a, VA);
      chk(val_b, 24'h00_0000);
      chk(cap_a, VA);
   endtask : test_load_a
   task automatic test_load_b;
      shift_nib(VB, 1'b1);
      shift_nib(24'h55_5555, 1'b1);
      strobe(1'b1);
      chk(val_b, VB);
      chk(val_a, VA);
      chk(cap_b, VB);
      chk(caps[23:0], 24'h00_0002);
   endtask : test_load_b
   task automatic summarize;
      $display("mismatches %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (8) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_clock);
      test_reset();
      test_load_a();
      test_load_b();
      summarize();
   end
   // Whole run is well under 1000 cycles
   initial begin
      #(50 * 5000);
      err_count++;
      summarize();
   end
endmodule : nbcd_output_port_test

// [nbcd_pkg.sv]
package nbcd_pkg;
   // Geometry
   localparam int unsigned NBCD_DIGITS       = 6;
   localparam int unsigned NBCD_STAGES       = 8;
   localparam int unsigned NBCD_BCD_W        = 4;
   localparam int unsigned NBCD_SYNC_DEPTH   = 3;
   // Timing
   localparam int unsigned NBCD_CLK_NS       = 50;
   localparam int unsigned NBCD_INHIBIT_NS   = 2000;
   localparam int unsigned NBCD_INHIBIT_CYC  = (NBCD_INHIBIT_NS + NBCD_CLK_NS - 1) / NBCD_CLK_NS;
   localparam int unsigned NBCD_CNT_W        = 6;
   // Reset values
   localparam logic [NBCD_STAGES-1:0] NBCD_REG_RST = 8'h00;
   localparam logic [NBCD_CNT_W-1:0]  NBCD_CNT_RST = 6'h00;

   // Pins arriving from the processor control logic
   typedef struct packed {
      logic                   load_strobe_second;
      logic                   load_strobe_first;
      logic                   serial_clock_second_reading;
      logic                   serial_clock_first_reading;
      logic [NBCD_DIGITS-1:0] serial_data;
   } nbcd_pins_t;

   localparam nbcd_pins_t NBCD_PINS_RST = '0;
endpackage : nbcd_pkg

// [nbcd_pkg_unused_guard.sv]
`timescale 1ns/1ps

// [nbcd_telemetry_model.sv]
`timescale 1ns/1ps
module nbcd_telemetry_model (
   // Observed lines
   input  wire logic        i_update_inhibit,
   input  wire logic [23:0] i_value_a,
   input  wire logic [23:0] i_value_b,
   // Captured words
   output logic [23:0]      o_cap_a,
   output logic [23:0]      o_cap_b,
   output int               o_caps
);
   logic armed = 1'b0;
   int   count = 0;
   assign o_caps = count;
   // Armed by a real pulse, so the unknown-to-low step at power-up is no capture
   always @(posedge i_update_inhibit) armed <= 1'b1;
   // Lines are only read once inhibit has dropped; data is in motion while high
   always @(negedge i_update_inhibit) begin
      if (armed) begin
         o_cap_a <= i_value_a;
         o_cap_b <= i_value_b;
         count   <= count + 1;
      end
   end
endmodule : nbcd_telemetry_model
